// File: verilog/dbg_auth_cfg.svh
/*
 * Offsets, field positions, reset values and encodings of the debug
 * authentication status and exception catch block.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef DBG_AUTH_CFG_SVH
`define DBG_AUTH_CFG_SVH

`define OFF_AUTH_STATUS      8'h00
`define OFF_CTI_AUTH_STATUS  8'h04
`define OFF_EXC_CATCH        8'h08
`define OFF_IRQ_STATUS       8'h0c
`define OFF_IRQ_MASK         8'h10
`define OFF_TOP_CATCH        8'h14

`define POS_SECURE_INV       4
`define POS_REALM_INV        12
`define POS_REALM_NONINV     14
`define POS_ROOT_INV         24
`define POS_ROOT_NONINV      26
`define POS_ENTRY_CATCH      16
`define POS_RETURN_CATCH     20
`define POS_TOP_ENTRY        0
`define POS_TOP_RETURN       1

`define CODE_NOT_IMPL        2'h0
`define CODE_DISABLED        2'h2
`define CODE_ENABLED         2'h3

`define CATCH_RESET          3'h0
`define CATCH_LEVEL0_MASK    3'h6
`define CTI_RAZ_MASK         32'h0f00f000
`define IRQ_RESET            2'h0

`endif

// File: verilog/dbg_auth_pkg.sv
/*
 * Types shared by the debug authentication and exception catch block.
 * Assumes the constants header sits on the include path.
 */
package dbg_auth_pkg;

    typedef struct packed {
        logic [2:0] entry;
        logic [2:0] ret;
    } catch_fields_t;

    typedef struct packed {
        logic       entry_catch;
        logic       return_catch;
    } catch_hit_t;

    typedef struct packed {
        logic       valid;
        logic       entry;
        logic [1:0] level;
        logic       realm;
    } exc_event_t;

endpackage

// File: verilog/dbg_auth_catch.sv
/*
 * Debug authentication status, cross-trigger authentication status and
 * exception catch control, reached over a classic Wishbone slave.
 * Assumes the debug enables and exception events are synchronous to
 * SYS_CLK, and that RST_B is the cold reset; warm and external debug
 * resets arrive as plain synchronous inputs.
 */
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
// Functional notes
// - Root invasive status at bits 25:24 reads 00 absent, 10 disabled, 11 enabled.
// - Root non-invasive status at bits 27:26 always equals the root invasive status.
// - Realm invasive status at bits 13:12 reads 00 absent, 10 disabled, 11 enabled.
// - Realm non-invasive status at bits 15:14 always equals the realm invasive status.
// - Without Secure state the secure invasive status at bits 5:4 reads 00.
// - With Secure state the secure invasive status reads 10 disabled or 11 enabled.
// - Realm entry catch sits at bits 18:16, one bit per level, with level 0 reading zero.
// - Realm return catch sits at bits 22:20, one bit per level, paired with entry catch.
// - Per level entry/return 00 none, 01 returns, 10 entry and return, 11 entry only.
// - Both realm catch fields clear to zero on cold reset.
// - Both realm catch fields keep their values through warm and external debug reset.
// - Without the realm feature both realm catch fields read zero and ignore writes.
// - Catch at the top level stays under the top-level entry and return bits alone.
// - With the os lock flag set the system view maps onto the same catch storage.
`timescale 1ns/10ps
`include "dbg_auth_cfg.svh"

module dbg_auth_catch #(
    parameter bit REALM_PRESENT  = 1'b1,
    parameter bit ROOT_PRESENT   = 1'b1,
    parameter bit SECURE_PRESENT = 1'b1
) (
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_B,
    input  wire logic                    WARM_RESET,
    input  wire logic                    EXT_DEBUG_RESET,
    input  wire logic                    CYC_I,
    input  wire logic                    STB_I,
    input  wire logic                    WE_I,
    input  wire logic [7:0]              ADR_I,
    input  wire logic [3:0]              SEL_I,
    input  wire logic [31:0]             DAT_I,
    output logic      [31:0]             DAT_O,
    output logic                         ACK_O,
    input  wire logic                    ROOT_DEBUG_EN,
    input  wire logic                    REALM_DEBUG_EN,
    input  wire logic                    SECURE_DEBUG_EN,
    input  wire logic                    OS_LOCK_FLAG,
    input  wire logic                    SYS_VIEW_WE,
    input  wire logic [31:0]             SYS_VIEW_WDATA,
    output logic      [31:0]             SYS_VIEW_RDATA,
    input  wire dbg_auth_pkg::exc_event_t EXC_EVENT,
    output dbg_auth_pkg::catch_hit_t     CATCH_HIT,
    output logic                         IRQ
);
    import dbg_auth_pkg::*;

    catch_fields_t realm_catch;
    logic [1:0]    top_catch;
    logic [1:0]    irq_status;
    logic [1:0]    irq_mask;
    logic [31:0]   auth_status;
    logic [31:0]   cti_status;
    logic [31:0]   exc_catch_word;
    logic [31:0]   next_dat;
    logic [31:0]   wmask;
    logic [31:0]   wdata;
    logic          bus_req;
    logic          bus_wr;
    logic          sys_wr;
    logic          hit_entry;
    logic          hit_return;
    logic [1:0]    root_code;
    logic [1:0]    realm_code;
    logic [1:0]    secure_code;

    assign bus_req = CYC_I & STB_I & ~ACK_O;
    assign bus_wr  = bus_req & WE_I;
    assign sys_wr  = SYS_VIEW_WE & OS_LOCK_FLAG;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[8*g +: 8] = {8{SEL_I[g]}};
        end
    endgenerate
    assign wdata = bus_wr ? ((DAT_I & wmask) | (exc_catch_word & ~wmask)) : SYS_VIEW_WDATA;

    always_comb begin
        root_code = `CODE_NOT_IMPL;
        if (ROOT_PRESENT) begin
            root_code = ROOT_DEBUG_EN ? `CODE_ENABLED : `CODE_DISABLED;
        end
        realm_code = `CODE_NOT_IMPL;
        if (REALM_PRESENT) begin
            realm_code = REALM_DEBUG_EN ? `CODE_ENABLED : `CODE_DISABLED;
        end
        secure_code = `CODE_NOT_IMPL;
        if (SECURE_PRESENT) begin
            secure_code = SECURE_DEBUG_EN ? `CODE_ENABLED : `CODE_DISABLED;
        end
    end

    always_comb begin
        auth_status = 32'h0;
        auth_status[`POS_ROOT_INV +: 2]     = root_code;
        auth_status[`POS_ROOT_NONINV +: 2]  = root_code;
        auth_status[`POS_REALM_INV +: 2]    = realm_code;
        auth_status[`POS_REALM_NONINV +: 2] = realm_code;
        auth_status[`POS_SECURE_INV +: 2]   = secure_code;
    end

    // Status of the cross-trigger unit carries the same domains minus the new fields
    assign cti_status = auth_status & ~`CTI_RAZ_MASK;

    always_comb begin
        exc_catch_word = 32'h0;
        exc_catch_word[`POS_ENTRY_CATCH +: 3]  = realm_catch.entry;
        exc_catch_word[`POS_RETURN_CATCH +: 3] = realm_catch.ret;
        exc_catch_word[`POS_TOP_ENTRY]         = top_catch[0];
        exc_catch_word[`POS_TOP_RETURN]        = top_catch[1];
    end
    assign SYS_VIEW_RDATA = OS_LOCK_FLAG ? exc_catch_word : 32'h0;

    // Only cold reset clears the catch fields; warm and debug resets are ignored here
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            realm_catch.entry <= `CATCH_RESET;
            realm_catch.ret   <= `CATCH_RESET;
            top_catch         <= 2'h0;
        end else if ((bus_wr && ADR_I == `OFF_EXC_CATCH) || sys_wr) begin
            if (REALM_PRESENT) begin
                realm_catch.entry <= wdata[`POS_ENTRY_CATCH +: 3] & `CATCH_LEVEL0_MASK;
                realm_catch.ret   <= wdata[`POS_RETURN_CATCH +: 3];
            end else begin
                realm_catch.entry <= `CATCH_RESET;
                realm_catch.ret   <= `CATCH_RESET;
            end
            top_catch <= {wdata[`POS_TOP_RETURN], wdata[`POS_TOP_ENTRY]};
        end
    end

    always_comb begin
        hit_entry  = 1'b0;
        hit_return = 1'b0;
        if (EXC_EVENT.valid) begin
            if (EXC_EVENT.level == 2'h3) begin
                hit_entry  = EXC_EVENT.entry & top_catch[0];
                hit_return = ~EXC_EVENT.entry & top_catch[1];
            end else if (EXC_EVENT.realm) begin
                case ({realm_catch.entry[EXC_EVENT.level], realm_catch.ret[EXC_EVENT.level]})
                    2'b01: hit_return = ~EXC_EVENT.entry;
                    2'b10: begin
                        hit_entry  = EXC_EVENT.entry;
                        hit_return = ~EXC_EVENT.entry;
                    end
                    2'b11: hit_entry = EXC_EVENT.entry;
                    default: begin
                        hit_entry  = 1'b0;
                        hit_return = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CATCH_HIT <= '0;
        end else begin
            CATCH_HIT.entry_catch  <= hit_entry;
            CATCH_HIT.return_catch <= hit_return;
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_status <= `IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~((bus_wr && ADR_I == `OFF_IRQ_STATUS) ? DAT_I[1:0] & wmask[1:0] : 2'h0))
                          | {hit_return, hit_entry};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_mask <= `IRQ_RESET;
        end else if (bus_wr && ADR_I == `OFF_IRQ_MASK) begin
            irq_mask <= DAT_I[1:0] & wmask[1:0];
        end
    end

    assign IRQ = |(irq_status & irq_mask);

    always_comb begin
        case (ADR_I)
            `OFF_AUTH_STATUS:     next_dat = auth_status;
            `OFF_CTI_AUTH_STATUS: next_dat = cti_status;
            `OFF_EXC_CATCH:       next_dat = exc_catch_word;
            `OFF_IRQ_STATUS:      next_dat = {30'h0, irq_status};
            `OFF_IRQ_MASK:        next_dat = {30'h0, irq_mask};
            default:              next_dat = 32'h0;
        endcase
    end

    // One-cycle answer; ack drops the cycle after so back-to-back needs a gap
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0;
        end else begin
            ACK_O <= bus_req;
            if (bus_req && !WE_I) begin
                DAT_O <= next_dat;
            end
        end
    end

endmodule // dbg_auth_catch

// File: tb/dbg_auth_catch_properties.sv
/* Concurrent checks on the debug status and catch block.
   Sees only the top-level ports; bound from tb_top. */
`timescale 1ns/10ps
module dbg_auth_checker (
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        ROOT_DEBUG_EN,
    input wire logic        REALM_DEBUG_EN,
    input wire logic        SECURE_DEBUG_EN,
    input wire logic        OS_LOCK_FLAG,
    input wire logic        SYS_VIEW_WE,
    input wire logic [31:0] SYS_VIEW_RDATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    sequence rd(logic [7:0] a);
        ACK_O && !WE_I && ADR_I == a;
    endsequence
    chk_ack_once: assert property (ACK_O |=> !ACK_O)
        else $error("ack held too long");
    chk_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not answered");
    chk_root_code: assert property (rd(8'h00) |-> DAT_O[25:24] == {1'b1, $past(ROOT_DEBUG_EN)})
        else $error("root status code wrong");
    chk_root_mirror: assert property (rd(8'h00) |-> DAT_O[27:26] == DAT_O[25:24])
        else $error("root mirror differs");
    chk_realm_code: assert property (rd(8'h00) |-> DAT_O[13:12] == {1'b1, $past(REALM_DEBUG_EN)})
        else $error("realm status code wrong");
    chk_realm_mirror: assert property (rd(8'h00) |-> DAT_O[15:14] == DAT_O[13:12])
        else $error("realm mirror differs");
    chk_secure_code: assert property (rd(8'h00) |-> DAT_O[5:4] == {1'b1, $past(SECURE_DEBUG_EN)})
        else $error("secure status code wrong");
    chk_cti_raz: assert property (rd(8'h04) |-> (DAT_O & 32'h0f00f000) == 32'h0)
        else $error("cti reserved bits set");
    chk_level0_raz: assert property (rd(8'h08) |-> !DAT_O[16] && !DAT_O[19])
        else $error("catch reserved bits set");
    // A system write just before the read would legally split the two views
    chk_sys_view: assert property (rd(8'h08) ##0 (OS_LOCK_FLAG && !$past(SYS_VIEW_WE))
        |-> DAT_O == SYS_VIEW_RDATA)
        else $error("system view differs from catch register");
endmodule // dbg_auth_checker

// File: tb/dbg_debugger_model.sv
/* External debugger model: classic Wishbone master.
   Assumes a slave that answers with a one-cycle ack. */
`timescale 1ns/10ps
module dbg_debugger_model (
    input  wire logic        SYS_CLK,
    input  wire logic        ACK_O,
    input  wire logic [31:0] DAT_O,
    output logic             CYC_I,
    output logic             STB_I,
    output logic             WE_I,
    output logic [7:0]       ADR_I,
    output logic [3:0]       SEL_I,
    output logic [31:0]      DAT_I
);
    initial begin
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 8'h00;
        SEL_I = 4'hf;
        DAT_I = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge SYS_CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= d;
        do @(posedge SYS_CLK); while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        // Released data must not look like a still-valid write
        DAT_I <= ~d;
    endtask
endmodule // dbg_debugger_model

// File: tb/tb_top.sv
/* Self-checking bench for the debug status and catch block.
   Bus traffic goes through the debugger model. */
`timescale 1ns/10ps
module tb_top;
    import dbg_auth_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        warm = 1'b0;
    logic        edbg = 1'b0;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, sv_rd;
    logic [31:0] sv_wd = 32'h0;
    logic [2:0]  en = 3'h0;
    logic [1:0]  cv;
    logic        os_lock_flag = 1'b0;
    logic        sv_we = 1'b0;
    exc_event_t  ev = '0;
    catch_hit_t  hit;
    int          mismatches = 0;
    int          n_checks = 0;
    always #4 clk = ~clk;
    dbg_auth_catch DUT (.SYS_CLK(clk), .RST_B(rst_b), .WARM_RESET(warm), .EXT_DEBUG_RESET(edbg),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .ROOT_DEBUG_EN(en[2]), .REALM_DEBUG_EN(en[1]), .SECURE_DEBUG_EN(en[0]),
        .OS_LOCK_FLAG(os_lock_flag), .SYS_VIEW_WE(sv_we), .SYS_VIEW_WDATA(sv_wd), .SYS_VIEW_RDATA(sv_rd),
        .EXC_EVENT(ev), .CATCH_HIT(hit), .IRQ(irq));
    dbg_debugger_model dbg (.SYS_CLK(clk), .ACK_O(ack), .DAT_O(rdat), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat));
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        dbg.xfer(1'b1, a, d, q);
    endtask
    task ev_chk(input string n, input logic e, input logic [1:0] l, input logic r, input logic [1:0] x);
        @(posedge clk);
        ev <= '{1'b1, e, l, r};
        @(posedge clk);
        ev <= '0;
        #1 check(n, {30'h0, hit}, {30'h0, x});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            en <= i[2:0];
            dbg.xfer(1'b0, 8'h00, 32'h0, q);
            check("auth", q & 32'h0f00f030, {4'h0, {2{1'b1, en[2]}}, 8'h0, {2{1'b1, en[1]}}, 6'h0, 1'b1, en[0], 4'h0});
            dbg.xfer(1'b0, 8'h04, 32'h0, q);
            check("cti", q & 32'h0f00f030, {26'h0, 1'b1, en[0], 4'h0});
        end
        wr(8'h08, 32'hffffffff);
        dbg.xfer(1'b0, 8'h08, 32'h0, q);
        check("catch", q, 32'h00760003);
        warm <= 1'b1;
        edbg <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        edbg <= 1'b0;
        dbg.xfer(1'b0, 8'h08, 32'h0, q);
        check("keep", q, 32'h00760003);
        wr(8'h14, 32'hffffffff);
        dbg.xfer(1'b0, 8'h14, 32'h0, q);
        check("unmapped", q, 32'h0);
        for (int c = 0; c < 4; c++) begin
            cv = c[1:0];
            wr(8'h08, {10'h0, cv[0], 3'h0, cv[1], 17'h0});
            ev_chk("entry", 1'b1, 2'h1, 1'b1, {cv[1], 1'b0});
            ev_chk("return", 1'b0, 2'h1, 1'b1, {1'b0, ^cv});
        end
        wr(8'h08, 32'h1);
        ev_chk("top", 1'b1, 2'h3, 1'b0, 2'b10);
        wr(8'h0c, 32'h3);
        wr(8'h10, 32'h0);
        ev_chk("top", 1'b1, 2'h3, 1'b0, 2'b10);
        check("masked", {31'h0, irq}, 32'h0);
        dbg.xfer(1'b0, 8'h0c, 32'h0, q);
        check("status", q, 32'h1);
        wr(8'h10, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(8'h0c, 32'h1);
        check("cleared", {31'h0, irq}, 32'h0);
        os_lock_flag <= 1'b1;
        sv_we <= 1'b1;
        sv_wd <= 32'h00220000;
        @(posedge clk);
        sv_we <= 1'b0;
        dbg.xfer(1'b0, 8'h08, 32'h0, q);
        check("sysview", q, 32'h00220000);
        check("sysread", sv_rd, 32'h00220000);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        dbg.xfer(1'b0, 8'h08, 32'h0, q);
        check("cold", q, 32'h0);
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test;
    end
endmodule // tb_top
bind dbg_auth_catch dbg_auth_checker chk (.*);
